// file: lsl_pkg.sv
package lsl_pkg;
  // word width and synchroniser depth
  localparam int LSL_WIDTH = 16;
  localparam int LSL_SYNC_STAGES = 2;
  // reset values
  localparam logic [15:0] LSL_SHIFT_RST = 16'h0000;
  localparam logic [15:0] LSL_LATCH_RST = 16'h0000;
  localparam logic [1:0] LSL_SYNC_RST = 2'h0;
  // bit positions
  localparam int LSL_MSB_POS = 15;
  localparam int LSL_LSB_POS = 0;
  // cycles from a link clock edge to the shift register update (the edge pulse comes one cycle earlier)
  localparam int LSL_EDGE_LAT = 3;

  // serial link inputs from the host controller
  typedef struct packed {
    logic serial_clock;
    logic serial_data;
    logic latch_load;
    logic output_enable_n;
  } lsl_link_s;

  // per-pin sink drive: output enable plus level
  typedef struct packed {
    logic [15:0] oe;
    logic [15:0] level;
  } lsl_sink_s;
endpackage : lsl_pkg

// file: lsl_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser and edge finder for one link pin
module lsl_sync (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic pin_in,
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);
  import lsl_pkg::*;

  logic [1:0] sync_reg; // [0] first stage, read only by [1]
  logic [1:0] sync_next;
  logic prev_reg; // delayed copy of the clean level
  logic prev_next;

  // next state: shift the pin through both stages
  always_comb begin
    sync_next = {sync_reg[0], pin_in};
    prev_next = sync_reg[1];
  end

  // register stage with synchronous reset
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      sync_reg <= LSL_SYNC_RST;
      prev_reg <= 1'b0;
    end else begin
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  // edges come from the second stage and its delayed copy only
  assign level_out = sync_reg[1];
  assign rise_out = sync_reg[1] & ~prev_reg;
  assign fall_out = ~sync_reg[1] & prev_reg;
endmodule : lsl_sync

// file: lsl_driver.sv
`timescale 1ns/1ps
// Summary of operation
// - shift serial data on serial clock rise
// - latches follow shift register while load high
// - load falling edge captures; hold while low
// - enable high releases all sinks, latches kept
// - enable low: each sink follows latch
// - last shift bit driven out on rise
// - sixteen open-drain sinks, on or released
// - input bit appears out sixteen clocks later
// - shift and latch ignore output enable
module lsl_driver (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire lsl_pkg::lsl_link_s link_in,
  output logic serial_data_out,
  output lsl_pkg::lsl_sink_s led_sink_outputs_out
);
  import lsl_pkg::*;

  logic clk_rise; // serial clock rising edge pulse
  logic data_lvl; // synchronised serial data
  logic load_lvl; // synchronised latch_load level
  logic load_fall; // latch_load falling edge pulse
  logic oen_lvl; // synchronised output enable, low active

  // serial clock edge finder
  lsl_sync u_clk_sync (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .pin_in(link_in.serial_clock),
    .level_out(),
    .rise_out(clk_rise),
    .fall_out()
  );

  // serial data synchroniser; same depth keeps it aligned with clock
  lsl_sync u_data_sync (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .pin_in(link_in.serial_data),
    .level_out(data_lvl),
    .rise_out(),
    .fall_out()
  );

  // latch_load synchroniser
  lsl_sync u_load_sync (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .pin_in(link_in.latch_load),
    .level_out(load_lvl),
    .rise_out(),
    .fall_out(load_fall)
  );

  // output enable synchroniser
  lsl_sync u_oen_sync (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .pin_in(link_in.output_enable_n),
    .level_out(oen_lvl),
    .rise_out(),
    .fall_out()
  );

  logic [15:0] shift_reg; // serial shift register
  logic [15:0] shift_next;
  logic [15:0] latch_reg; // output latches
  logic [15:0] latch_next;
  logic sdo_reg; // serial data out
  logic sdo_next;
  lsl_sink_s sink_reg; // sink pin drive
  lsl_sink_s sink_next;

  // shift path and latch path, independent of enable
  always_comb begin
    shift_next = shift_reg;
    sdo_next = sdo_reg;
    if (clk_rise) begin
      shift_next = {shift_reg[LSL_MSB_POS-1:0], data_lvl};
      sdo_next = shift_reg[LSL_MSB_POS];
    end
    latch_next = latch_reg;
    if (load_lvl) begin
      latch_next = shift_next;
    end else if (load_fall) begin
      latch_next = shift_reg;
    end
  end

  // sink drive per channel
  always_comb begin
    for (int n = LSL_LSB_POS; n < LSL_WIDTH; n++) begin
      // pulling low only; released pins are not driven
      sink_next.level[n] = 1'b0;
      // on when enabled and latch bit set
      sink_next.oe[n] = ~oen_lvl & latch_reg[n];
    end
  end

  // register all state
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      shift_reg <= LSL_SHIFT_RST;
      latch_reg <= LSL_LATCH_RST;
      sdo_reg <= 1'b0;
      sink_reg <= '0;
    end else begin
      shift_reg <= shift_next;
      latch_reg <= latch_next;
      sdo_reg <= sdo_next;
      sink_reg <= sink_next;
    end
  end

  assign serial_data_out = sdo_reg;
  assign led_sink_outputs_out = sink_reg;

  // outputs released while disabled
  property p_disable;
    @(posedge clk_in) disable iff (!rstn_in)
      oen_lvl |=> sink_reg.oe == 16'h0000;
  endproperty
  sink_release_a: assert property (p_disable)
    else $error("sink driven while disabled");

  // outputs follow latch when enabled
  property p_follow;
    @(posedge clk_in) disable iff (!rstn_in)
      !oen_lvl |=> sink_reg.oe == $past(latch_reg);
  endproperty
  sink_follow_a: assert property (p_follow)
    else $error("sink does not follow latch");

  // open drain never drives high
  open_drain_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
      sink_reg.level == 16'h0000)
    else $error("sink level driven high");

  // shift on edge
  shift_edge_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
      clk_rise |=> shift_reg == {$past(shift_reg[14:0]), $past(data_lvl)})
    else $error("shift missed");

  // shift register still without edges
  shift_hold_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
      !clk_rise |=> $stable(shift_reg))
    else $error("shift without edge");

  // serial out carries leaving bit
  sdo_bit_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
      clk_rise |=> sdo_reg == $past(shift_reg[15]))
    else $error("serial out wrong");

  // transparent load
  latch_open_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
      load_lvl |=> latch_reg == shift_reg)
    else $error("latch not transparent");

  // hold while low
  sequence s_closed;
    !load_lvl && !load_fall;
  endsequence
  latch_hold_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
      s_closed |=> $stable(latch_reg))
    else $error("latch changed while closed");

  // capture on falling edge
  latch_capture_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
      load_fall |=> latch_reg == $past(shift_reg))
    else $error("capture wrong");

  // serial out stands between link clock edges
  sdo_hold_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
      !clk_rise |=> $stable(sdo_reg))
    else $error("serial out changed without edge");

  // one pulse per link clock edge, so one shift per edge
  clk_pulse_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
      clk_rise |=> !clk_rise)
    else $error("edge pulse held");

  // disabling keeps the stored latch contents
  latch_keep_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
      oen_lvl && !load_lvl && !load_fall |=> $stable(latch_reg))
    else $error("latch changed by enable");

  // a sink is only on where its latch bit is one
  sink_bit_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
      1'b1 |=> (sink_reg.oe & ~$past(latch_reg)) == 16'h0000)
    else $error("sink on without latch bit");

  // open latch, then its falling edge: the last open value is kept
  sequence s_open;
    load_lvl;
  endsequence
  sequence s_drop;
    load_fall;
  endsequence
  latch_close_a: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
      s_open ##1 s_drop |=> $stable(latch_reg))
    else $error("latch moved on close");

  // synchronous reset clears every output register
  reset_clear_a: assert property (
    @(posedge clk_in)
      !rstn_in |=> sink_reg.oe == 16'h0000 && sink_reg.level == 16'h0000
        && !sdo_reg)
    else $error("outputs not cleared by reset");
endmodule : lsl_driver

// file: lsl_host.sv
`timescale 1ns/1ps
// host controller model driving the four link pins
module lsl_host (
  input wire logic clk_in,
  output lsl_pkg::lsl_link_s link_out
);
  import lsl_pkg::*;
  // idle pins: clock low, latch low, sinks disabled
  task automatic idle_pins();
    link_out <= 4'h1;
  endtask : idle_pins
  // one bit in 16 cycles: data set with clock low, clock rises mid-bit
  task automatic send_bit(input logic b);
    @(posedge clk_in);
    link_out.serial_clock <= 1'b0;
    link_out.serial_data <= b;
    repeat (8) @(posedge clk_in);
    link_out.serial_clock <= 1'b1;
    // the next call's own edge completes the high phase
    repeat (7) @(posedge clk_in);
    // step off the edge so callers read settled outputs
    #1;
  endtask : send_bit
  // whole word, then clock stops and data shows the inverse
  task automatic send_word(input logic [15:0] w);
    for (int i = LSL_MSB_POS; i >= LSL_LSB_POS; i--) begin
      send_bit(w[i]);
    end
    @(posedge clk_in);
    link_out.serial_clock <= 1'b0;
    link_out.serial_data <= ~w[0];
    #1;
  endtask : send_word
  // latch load level, held long enough to pass the synchroniser
  task automatic set_latch(input logic v);
    @(posedge clk_in);
    link_out.latch_load <= v;
    repeat (8) @(posedge clk_in);
    #1;
  endtask : set_latch
  // output enable level, active low
  task automatic set_enable_n(input logic v);
    @(posedge clk_in);
    link_out.output_enable_n <= v;
    repeat (8) @(posedge clk_in);
    #1;
  endtask : set_enable_n
endmodule : lsl_host

// file: led_shift_latch_driver_bench.sv
`timescale 1ns/1ps
// self-checking bench for the shift and latch driver
module led_shift_latch_driver_bench;
  import lsl_pkg::*;
  logic clk_in;
  logic rstn_in;
  lsl_link_s link;
  logic sdo;
  lsl_sink_s sink;
  int failures;
  int cmp_count;
  int cycles;
  // word patterns handed to the host model
  logic [15:0] pat [6] = '{16'ha5c3, 16'h1234, 16'hffff, 16'h0f0f,
    16'h3c96, 16'h8001};
  lsl_driver lsl_driver_inst (.clk_in(clk_in), .rstn_in(rstn_in),
    .link_in(link), .serial_data_out(sdo), .led_sink_outputs_out(sink));
  lsl_host lsl_host_inst (.clk_in(clk_in), .link_out(link));
  // compare; callers come here off the clock edge
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // counts, verdict, end of run
  task automatic final_report();
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  // sixteen-bit compare, widened on purpose
  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    check({16'h0000, got}, {16'h0000, exp});
  endtask : check16
  // latch a word through a load pulse, high then low
  task automatic load_pulse();
    for (int v = 1; v >= 0; v--) begin
      lsl_host_inst.set_latch(v[0]);
    end
  endtask : load_pulse
  // word loaded and enabled appears on the sinks, bit n on sink n
  task automatic t_load();
    lsl_host_inst.set_enable_n(1'b0);
    lsl_host_inst.send_word(pat[0]);
    load_pulse();
    check(sink, {16'ha5c3, 16'h0000});
  endtask : t_load
  // disabled sinks released; shifting and latching go on meanwhile
  task automatic t_enable();
    lsl_host_inst.set_enable_n(1'b1);
    check16(sink.oe, 16'h0000);
    lsl_host_inst.send_word(pat[1]);
    load_pulse();
    check16(sink.oe, 16'h0000);
    lsl_host_inst.set_enable_n(1'b0);
    check16(sink.oe, 16'h1234);
  endtask : t_enable
  // latch holds while load stays low
  task automatic t_hold();
    lsl_host_inst.send_word(pat[2]);
    check16(sink.oe, 16'h1234);
  endtask : t_hold
  // load high: latch follows the shift register and the shifting bits
  task automatic t_transp();
    lsl_host_inst.set_latch(1'b1);
    check16(sink.oe, 16'hffff);
    lsl_host_inst.send_word(pat[3]);
    check16(sink.oe, 16'h0f0f);
    lsl_host_inst.set_latch(1'b0);
  endtask : t_transp
  // old word leaves on the cascade output sixteen shifts later
  task automatic t_cascade();
    for (int k = 0; k < 16; k++) begin
      lsl_host_inst.send_bit(pat[4][15-k]);
      check({31'h0, sdo}, {31'h0, 1'(16'h0f0f >> (15 - k))});
    end
    load_pulse();
    check16(sink.oe, 16'h3c96);
  endtask : t_cascade
  // reset in mid-run clears everything, the link works again after
  task automatic t_reset();
    @(posedge clk_in);
    rstn_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    check(sink, 32'h0);
    check({31'h0, sdo}, 32'h0);
    lsl_host_inst.send_word(pat[5]);
    load_pulse();
    check16(sink.oe, 16'h8001);
  endtask : t_reset
  // free running clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // hang guard
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 10000) begin
      failures++;
      final_report();
    end
  end
  // main sequence
  initial begin
    lsl_host_inst.idle_pins();
    rstn_in = 1'b0;
    repeat (5) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    check(sink, 32'h0);
    check({31'h0, sdo}, 32'h0);
    t_load();
    t_enable();
    t_hold();
    t_transp();
    t_cascade();
    t_reset();
    final_report();
  end
endmodule : led_shift_latch_driver_bench
